// file: hw/isa_bus_control.sv
/*
 * Control-signal side of the expansion-bus port: cycle sequencing with
 * ready extension and zero-wait end, address strobes, terminal count,
 * DMA arbitration with encoded grant, and the strap-selected shared
 * reset / activity pin.
 * Assumes all inputs are synchronous to the 25 MHz clock; the host side
 * launches cycles with cycle_start and drives dma word-count status.
 */
// How it works
// - slave holding ready low keeps cycle open past default timer
// - address latch enable pulses while a fresh address is presented
// - address enable stays high for the whole DMA cycle
// - terminal count asserted when serviced channel count expires
// - seven request inputs, channels 0-3 and 5-7, accepted
// - grant shown as 3-bit binary winner; outside logic decodes strobes
// - no grant drives encoded value 100
// - bus-reset mode: one-millisecond reset after power-good rising
// - hot-reset bit write starts the reset pulse
// - reset-drive bit write starts the reset pulse
// - bus reset driven high while rstn is held low
// - strap sampled after power-up picks shared pin function
// - x86 mode: activity output goes active on a break event
// - break event set chosen by software mask registers 60h-63h
// - zero-wait input ends cycle before default timer expires
`timescale 1ns/1ps
module isa_bus_control
	import isa_ctl_pkg::*;
#(
	parameter int pulse_cycles = reset_pulse_cycles
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic power_good_in,
	input wire logic mode_strap,
	input wire logic cycle_start,
	input wire logic cycle_is_dma,
	output logic cycle_done,
	input wire logic channel_ready,
	input wire logic zero_wait_n,
	output logic address_latch_enable,
	output logic address_enable,
	input wire logic word_count_expired,
	output logic terminal_count,
	input wire logic [7:0] dma_request,
	input wire logic dma_grant_enable,
	output logic [2:0] encoded_dma_grant,
	input wire logic hot_reset_write,
	input wire logic [7:0] hot_reset_data,
	input wire logic clock_divisor_write,
	input wire logic [7:0] clock_divisor_data,
	input wire logic [31:0] pm_break_mask,
	input wire logic [31:0] pm_break_events,
	input wire logic pm_activity_clear,
	output logic x86_mode,
	output logic expansion_bus_reset_out,
	output logic power_mgmt_activity_out_n
);
	cycle_state_t state;
	logic [3:0] wait_count;
	logic strap_taken;
	logic pg_prev;
	logic reset_trigger;
	logic reset_active;
	logic activity;
	logic [7:0] live_req;
	logic [2:0] next_grant;

	// ==========================================================
	// strap capture
	// sampled once after release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_taken <= 1'b0;
			x86_mode <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			x86_mode <= mode_strap;
		end
	end

	// ==========================================================
	// cycle sequencer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= st_idle;
			wait_count <= 4'h0;
		end else begin
			case (state)
				st_idle: begin
					if (cycle_start) begin
						state <= st_ale;
					end
				end
				st_ale: begin
					state <= st_cmd;
					wait_count <= 4'(default_wait_cycles);
				end
				st_cmd: begin
					if (wait_count != 4'h0) begin
						wait_count <= wait_count - 4'h1;
					end
					if (!zero_wait_n) begin
						state <= st_done;
					end else if (wait_count == 4'h0 && channel_ready) begin
						state <= st_done;
					end
				end
				st_done: begin
					state <= st_idle;
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	logic dma_cycle;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dma_cycle <= 1'b0;
		end else if (state == st_idle && cycle_start) begin
			dma_cycle <= cycle_is_dma;
		end
	end

	// ==========================================================
	// strobes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			address_latch_enable <= 1'b0;
			address_enable <= 1'b0;
			cycle_done <= 1'b0;
			terminal_count <= 1'b0;
		end else begin
			address_latch_enable <= state == st_idle && cycle_start;
			address_enable <= (state == st_idle) ?
				(cycle_start && cycle_is_dma) :
				(dma_cycle && state != st_done);
			cycle_done <= state == st_cmd &&
				(!zero_wait_n || (wait_count == 4'h0 && channel_ready));
			terminal_count <= dma_cycle && state == st_cmd &&
				word_count_expired;
		end
	end

	// ==========================================================
	// DMA arbitration
	// only seven real channels
	assign live_req = dma_request & 8'hef;
	assign next_grant = pick_channel(live_req);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			encoded_dma_grant <= grant_idle;
		end else if (dma_grant_enable) begin
			encoded_dma_grant <= next_grant;
		end else begin
			encoded_dma_grant <= grant_idle;
		end
	end

	// ==========================================================
	// bus reset triggers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// high after reset: a steady power-good is no false edge
			pg_prev <= 1'b1;
		end else begin
			pg_prev <= power_good_in;
		end
	end

	assign reset_trigger = (power_good_in && !pg_prev) ||
		(hot_reset_write && hot_reset_data[hot_reset_bit]) ||
		(clock_divisor_write && clock_divisor_data[reset_drive_bit]);

	isa_reset_timer #(
		.pulse_cycles(pulse_cycles)
	) u_timer (
		.clk(clk),
		.rstn(rstn),
		.trigger(reset_trigger),
		.active(reset_active)
	);

	// ==========================================================
	// activity latch
	// masked break events
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			activity <= 1'b0;
		end else if (|(pm_break_events & pm_break_mask)) begin
			activity <= 1'b1;
		end else if (pm_activity_clear) begin
			activity <= 1'b0;
		end
	end

	// ==========================================================
	// shared pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			expansion_bus_reset_out <= 1'b1;
			power_mgmt_activity_out_n <= 1'b1;
		end else begin
			expansion_bus_reset_out <= !x86_mode && reset_active;
			power_mgmt_activity_out_n <= !(x86_mode && activity);
		end
	end
endmodule

// file: common/isa_ctl_pkg.sv
/*
 * Package for the expansion-bus control block: timing constants,
 * channel codes and the cycle state type.
 * Assumes a single 25 MHz clock domain.
 */
package isa_ctl_pkg;
	// ==========================================================
	// timing
	localparam int clk_mhz = 25;
	localparam int reset_pulse_us = 1000;
	localparam int reset_pulse_cycles = reset_pulse_us * clk_mhz;
	localparam int default_wait_cycles = 4;
	localparam int ale_cycles = 1;
	// ==========================================================
	// encodings
	localparam logic [2:0] grant_idle = 3'h4;
	localparam logic [2:0] pm_break_reset = 3'h0;
	localparam int hot_reset_bit = 0;
	localparam int reset_drive_bit = 3;
	localparam int pm_break_bits = 32;
	localparam logic [31:0] pm_break_mask_reset = 32'h0000_0000;
	localparam int req_width = 8;

	typedef enum logic [2:0] {
		st_idle,
		st_ale,
		st_cmd,
		st_done
	} cycle_state_t;

	// lowest numbered active request wins, cascade bit 4 never set
	function automatic logic [2:0] pick_channel(input logic [7:0] req);
		logic [2:0] ch;
		ch = grant_idle;
		for (int i = 7; i >= 0; i--) begin
			if (req[i] && i != 4) begin
				ch = 3'(i);
			end
		end
		return ch;
	endfunction
endpackage

// file: hw/isa_reset_timer.sv
/*
 * Retriggerable one-shot that times the expansion-bus reset pulse.
 * Assumes trigger pulses synchronous to clk.
 */
`timescale 1ns/1ps
module isa_reset_timer
	import isa_ctl_pkg::*;
#(
	parameter int pulse_cycles = reset_pulse_cycles
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic trigger,
	output logic active
);
	logic [31:0] count;

	// ==========================================================
	// interval counter
	// retrigger restarts interval
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= 32'h0;
		end else if (trigger) begin
			count <= 32'(pulse_cycles);
		end else if (count != 32'h0) begin
			count <= count - 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			active <= 1'b0;
		end else begin
			active <= trigger || count > 32'h1;
		end
	end
endmodule

// file: verif/isa_bus_control_assertions.sv
/* assertions on the expansion-bus control ports
   assumes one clock domain and rstn async active low */
`timescale 1ns/1ps
module isa_ctl_checker
	import isa_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cycle_start,
	input wire logic cycle_is_dma,
	input wire logic cycle_done,
	input wire logic channel_ready,
	input wire logic zero_wait_n,
	input wire logic address_latch_enable,
	input wire logic address_enable,
	input wire logic [7:0] dma_request,
	input wire logic dma_grant_enable,
	input wire logic [2:0] encoded_dma_grant,
	input wire logic expansion_bus_reset_out
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence s_open;
		$rose(address_latch_enable);
	endsequence
	// six stalled cycles reach the edge the default timer would end on
	sequence s_stall;
		(!channel_ready && zero_wait_n) [*6];
	endsequence
	a_ale_cause: assert property (address_latch_enable |->
		$past(cycle_start)) else $error("ale without start");
	a_aen_dma: assert property (address_latch_enable |->
		address_enable == $past(cycle_is_dma)) else $error("aen wrong");
	a_ready_ext: assert property (s_open ##1 s_stall |->
		!cycle_done) else $error("ready ignored");
	a_zws_early: assert property (s_open ##1 !zero_wait_n |->
		##[1:3] cycle_done) else $error("zero wait ignored");
	a_grant_idle: assert property (!dma_grant_enable ||
		!(|(dma_request & 8'hef)) |=> encoded_dma_grant == grant_idle)
		else $error("grant not idle");
	a_grant_low: assert property (dma_grant_enable && dma_request[0]
		|=> encoded_dma_grant == 3'h0) else $error("channel 0 lost");
	a_grant_five: assert property (dma_grant_enable &&
		(dma_request & 8'h2f) == 8'h20 |=> encoded_dma_grant == 3'h5)
		else $error("channel 5 lost");
	a_reset_holds: assert property ($rose(expansion_bus_reset_out)
		|-> expansion_bus_reset_out [*8]) else $error("bus reset short");
endmodule

bind isa_bus_control isa_ctl_checker watch (.clk, .rstn, .cycle_start,
	.cycle_is_dma, .cycle_done, .channel_ready, .zero_wait_n,
	.address_latch_enable, .address_enable, .dma_request,
	.dma_grant_enable, .encoded_dma_grant, .expansion_bus_reset_out);

// file: verif/isa_slave_card.sv
/* slave card model: stretches a cycle with ready or cuts it short
   assumes the address strobe opens each cycle */
`timescale 1ns/1ps
module isa_slave_card (
	input wire logic clk,
	input wire logic ale,
	input wire logic done,
	input wire logic zws,
	input wire logic [7:0] hold,
	output logic rdy,
	output logic zws_n
);
	logic [7:0] n = 8'h00;
	logic busy = 1'h0;
	// stall or early end; pull-ups lift released lines
	assign rdy = !busy || n == 8'h00;
	assign zws_n = !(busy && zws);
	always @(posedge clk) begin
		#1;
		n = ale ? hold : n - 8'(n != 8'h00);
		busy = ale || (busy && !done);
	end
endmodule

// file: verif/isa_bus_control_bench.sv
/* bench for the expansion-bus control block and a slave card
   assumes the reset pulse shortened to pw cycles */
`timescale 1ns/1ps
module isa_bus_control_bench;
	import isa_ctl_pkg::*;
	localparam int pw = 20;
	logic clk = 1'h0, rstn = 1'h0, pg = 1'h1, strap = 1'h0, st = 1'h0;
	logic dma = 1'h0, zws = 1'h0, wce = 1'h0, gen = 1'h0, hw = 1'h0;
	logic cw = 1'h0, clr = 1'h0, tcs, done, rdy, zn, ale, aen, tc;
	logic x86, brst, act_n;
	logic [7:0] req = 8'h00, hold = 8'h00, hd = 8'h01, cd = 8'h08;
	logic [2:0] gnt;
	logic [31:0] msk = 32'h0, ev = 32'h0;
	int n_errors = 0, compares = 0, seed = 32'hed674982, cyc = 0, a, b, w;
	always #20 clk = !clk;
	isa_bus_control #(.pulse_cycles(pw)) dut (.clk, .rstn,
		.power_good_in(pg), .mode_strap(strap), .cycle_start(st),
		.cycle_is_dma(dma), .cycle_done(done), .channel_ready(rdy),
		.zero_wait_n(zn), .address_latch_enable(ale),
		.address_enable(aen), .word_count_expired(wce),
		.terminal_count(tc), .dma_request(req), .dma_grant_enable(gen),
		.encoded_dma_grant(gnt), .hot_reset_write(hw),
		.hot_reset_data(hd), .clock_divisor_write(cw),
		.clock_divisor_data(cd), .pm_break_mask(msk),
		.pm_break_events(ev), .pm_activity_clear(clr), .x86_mode(x86),
		.expansion_bus_reset_out(brst), .power_mgmt_activity_out_n(act_n));
	isa_slave_card card (.clk, .ale, .done, .zws, .hold, .rdy, .zws_n(zn));
	task automatic chk(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// lowest channel wins; the cascade slot never does
	function automatic logic [2:0] exp_grant(input logic [7:0] r,
		input logic e);
		exp_grant = 3'h4;
		for (int i = 7; i >= 0; i--)
			if (e && r[i] && i != 4)
				exp_grant = 3'(i);
	endfunction
	task automatic do_reset(input logic m);
		rstn = 1'h0;
		strap = m;
		tick(4);
		chk(brst, 1);
		rstn = 1'h1;
		tick(2);
		chk(x86, m);
	endtask
	task automatic bus_cycle(input logic d, z, input int h, output int n);
		{dma, zws, wce, st} = {d, z, d, 1'h1};
		hold = 8'(h);
		tick(1);
		st = 1'h0;
		chk(ale, 1);
		chk(aen, d);
		n = 1;
		tcs = tc;
		while (!done && n < 60) begin
			tick(1);
			tcs |= tc;
			n++;
		end
		chk(done, 1);
		chk(aen, d);
		{wce, zws} = 2'h0;
		tick(1);
		chk(aen, 0);
	endtask
	// k picks the trigger: 0 hot reset, 1 divisor bit, 2 power good
	task automatic bus_reset(input int k, output int s, output int w);
		{hw, cw, pg} = {k == 0, k == 1, k != 2};
		tick(1);
		{hw, cw, pg} = 3'h1;
		s = 0;
		w = 0;
		while ((brst || w == 0) && s < 99) begin
			w += brst;
			s++;
			tick(1);
		end
	endtask
	initial begin
		do_reset(1'h0);
		bus_cycle(1'h0, 1'h0, 0, a);
		w = 12 + ($random(seed) & 3);
		bus_cycle(1'h1, 1'h0, w, b);
		chk(b, w + 2);
		chk(tcs, 1);
		bus_cycle(1'h0, 1'h1, 30, b);
		chk(b < a, 1);
		$display("bus cycles done");
		for (int i = 0; i < 40; i++) begin
			req = i < 8 ? 8'h01 << i : 8'($random(seed));
			gen = i % 9 != 8;
			tick(1);
			chk(gnt, exp_grant(req, gen));
		end
		gen = 1'h0;
		$display("grants done");
		for (int k = 2; k >= 0; k--) begin
			bus_reset(k, a, w);
			chk(w, pw);
		end
		hw = 1'h1;
		tick(1);
		hw = 1'h0;
		tick(8);
		bus_reset(0, b, w);
		chk(b, a);
		// writes without the trigger bits must leave the bus reset idle
		hd = 8'($random(seed)) & 8'hfe;
		cd = 8'($random(seed)) & 8'hf7;
		{hw, cw} = 2'h3;
		tick(1);
		{hw, cw} = 2'h0;
		tick(3);
		chk(brst, 0);
		$display("bus resets done");
		do_reset(1'h1);
		hd = 8'h01;
		hw = 1'h1;
		tick(1);
		hw = 1'h0;
		tick(2);
		chk(brst, 0);
		msk = $random(seed) | 32'h1;
		ev = ~msk;
		tick(2);
		chk(act_n, 1);
		ev = msk;
		tick(2);
		chk(act_n, 0);
		clr = 1'h1;
		tick(2);
		chk(act_n, 0);
		{ev, clr} = 33'h1;
		tick(2);
		clr = 1'h0;
		chk(act_n, 1);
		$display("activity done");
		close_out();
	end
endmodule
